/* File: core/std_timer_consts.vh */
// Register offsets, field positions and reset values of the compare/PWM timer
`ifndef STD_TIMER_CONSTS_VH
`define STD_TIMER_CONSTS_VH

// ***************************************
// Register offsets
// ***************************************
`define OFS_RUN_CONTROL   3'h0
`define OFS_MODE_CONTROL  3'h1
`define OFS_COUNT_LO      3'h2
`define OFS_COUNT_HI      3'h3
`define OFS_CMP_A_LO      3'h4
`define OFS_CMP_A_HI      3'h5
`define OFS_PERIOD_CMP    3'h6
`define OFS_FLAGS         3'h7

// ***************************************
// Run control fields
// ***************************************
`define BIT_PAUSE         7
`define POS_CLK_SEL       4
`define BIT_RUN           3

// ***************************************
// Mode control fields
// ***************************************
`define POS_OP_MODE       6
`define POS_PIN_ACTION    4
`define BIT_INIT_LEVEL    3
`define BIT_INVERT        2
`define BIT_SWAP          1
`define BIT_CLR_SEL       0

// ***************************************
// Flag register fields
// ***************************************
`define BIT_FLAG_A        0
`define BIT_FLAG_P        1

// ***************************************
// Codes
// ***************************************
`define MODE_COMPARE      2'h0
`define MODE_CAPTURE      2'h1
`define MODE_PWM          2'h2
`define MODE_TIMER        2'h3
`define ACT_NONE          2'h0
`define ACT_LOW           2'h1
`define ACT_HIGH          2'h2
`define ACT_TOGGLE        2'h3

// ***************************************
// Reset values
// ***************************************
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000

`endif

/* File: core/std_timer_compare_pwm.v */
// Sixteen-bit compare-match / PWM timer with register port and one output pin
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "std_timer_consts.vh"

// Operation
// - Compare mode: init bit sets starting pin level
// - PWM mode: init bit picks active level
// - Invert bit flips pin; unused in timer mode
// - Swap bit exchanges period and duty roles
// - Clear on A match, else P/overflow
// - P compares count high byte, low byte zero
// - PWM ignores clear-select bit
// - Mode 00 compare, mode 11 timer
// - Clear-select 0 raises both match flags in compare/timer
// - Clear-select 1 never raises P flag in compare/timer
// - Pin state changes only on A match or run rise
// - Action field: none, low, high, toggle
// - Run rising edge restores initial pin level
// - Timer mode counts like compare, no pin
// - Mode 10 with action 10 is PWM
// - PWM raises A and P flags
// - PWM forced levels keep counting running
// - Swap 0: period P*256, duty A
// - Duty at/above period gives full duty
// - Swap 1: period A, duty P*256
// - Clock select picks counter tick source
// - Run rise clears count; fall holds it
module std_timer_compare_pwm
(
  input  wire       REF_CLK,
  input  wire       RSTN,
  input  wire [2:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire       EXT_COUNT,
  input  wire       SUB_CLK,
  output reg        TIMER_OUT,
  output reg        TIMER_OUT_EN_N,
  output reg        MATCH_A_FLAG,
  output reg        MATCH_P_FLAG
);

  // ***************************************
  // Tick source decoding
  // ***************************************
  function tick_sel;
    input [2:0] sel;
    input [5:0] pre;
    input       sub_rise;
    input       ext_rise;
    input       ext_fall;
    begin
      case (sel)
        3'h0:    tick_sel = (pre[1:0] == 2'h3);
        3'h1:    tick_sel = 1'b1;
        3'h2:    tick_sel = (pre[3:0] == 4'hf);
        3'h3:    tick_sel = (pre == 6'h3f);
        3'h4:    tick_sel = sub_rise;
        3'h5:    tick_sel = sub_rise;
        3'h6:    tick_sel = ext_rise;
        default: tick_sel = ext_fall;
      endcase
    end
  endfunction

  // ***************************************
  // Registers
  // ***************************************
  reg  [7:0]  run_ctl_q;
  reg  [7:0]  mode_ctl_q;
  reg  [15:0] cmp_a_q;
  reg  [7:0]  period_cmp_q;
  reg         run_prev_q;
  reg  [15:0] count_q;
  reg  [15:0] count_d;
  reg  [5:0]  pre_q;
  reg         pin_state_q;
  reg         pin_state_d;
  reg         flag_a_q;
  reg         flag_p_q;
  reg  [2:0]  ext_sync_q;
  reg  [2:0]  sub_sync_q;
  reg         ext_lvl_q;
  reg         sub_lvl_q;
  reg         out_d;
  reg         out_en_n_d;
  reg         clr_a;
  reg         clr_p;
  reg         pwm_active;

  wire        run         = run_ctl_q[`BIT_RUN];
  wire        pause       = run_ctl_q[`BIT_PAUSE];
  wire [2:0]  clk_sel     = run_ctl_q[`POS_CLK_SEL+2:`POS_CLK_SEL];
  wire [1:0]  op_mode     = mode_ctl_q[`POS_OP_MODE+1:`POS_OP_MODE];
  wire [1:0]  pin_action  = mode_ctl_q[`POS_PIN_ACTION+1:`POS_PIN_ACTION];
  wire        init_level  = mode_ctl_q[`BIT_INIT_LEVEL];
  wire        invert      = mode_ctl_q[`BIT_INVERT];
  wire        swap        = mode_ctl_q[`BIT_SWAP];
  wire        clr_sel     = mode_ctl_q[`BIT_CLR_SEL];
  wire        run_rise    = run & ~run_prev_q;
  wire        wr_flags    = WR && (ADDR == `OFS_FLAGS);

  // ***************************************
  // Input synchronisers
  // ***************************************
  // Pins are asynchronous: an edge counts once stages two and three agree
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ext_sync_q <= 3'h0;
      sub_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
      sub_lvl_q  <= 1'b0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[1:0], EXT_COUNT};
      sub_sync_q <= {sub_sync_q[1:0], SUB_CLK};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_lvl_q <= ext_sync_q[2];
      if (sub_sync_q[1] == sub_sync_q[2])
        sub_lvl_q <= sub_sync_q[2];
    end
  end

  wire ext_agree = (ext_sync_q[1] == ext_sync_q[2]);
  wire sub_agree = (sub_sync_q[1] == sub_sync_q[2]);
  wire ext_rise  = ext_agree & ext_sync_q[2] & ~ext_lvl_q;
  wire ext_fall  = ext_agree & ~ext_sync_q[2] & ext_lvl_q;
  wire sub_rise  = sub_agree & sub_sync_q[2] & ~sub_lvl_q;

  // ***************************************
  // Tick and compare
  // ***************************************
  wire        tick     = tick_sel(clk_sel, pre_q, sub_rise, ext_rise, ext_fall);
  wire        counting = run & ~pause & ~run_rise & tick;
  wire [15:0] count_inc = count_q + 16'h0001;
  wire        match_a  = counting && (count_inc == cmp_a_q);
  // A zero period value matches at wrap, i.e. on overflow
  wire        match_p  = counting && (count_inc[15:8] == period_cmp_q)
                         && (count_inc[7:0] == 8'h00);

  // ***************************************
  // Mode decode
  // ***************************************
  always @*
  begin
    clr_a      = 1'b0;
    clr_p      = 1'b0;
    pwm_active = 1'b0;
    case (op_mode)
      `MODE_COMPARE, `MODE_TIMER:
      begin
        clr_a = clr_sel;
        clr_p = ~clr_sel;
      end
      `MODE_PWM:
      begin
        // Clear-select plays no part here
        clr_a = swap;
        clr_p = ~swap;
        if (!swap)
          pwm_active = (count_q < cmp_a_q);
        else
          pwm_active = (period_cmp_q == 8'h00)
                       || (count_q[15:8] < period_cmp_q);
      end
      default:
      begin
        clr_p = 1'b1;
      end
    endcase
  end

  // ***************************************
  // Counter and pin state
  // ***************************************
  always @*
  begin
    count_d     = count_q;
    pin_state_d = pin_state_q;
    if (run_rise)
    begin
      count_d     = `RST_WORD;
      pin_state_d = init_level;
    end
    else if (counting)
    begin
      if ((clr_a && match_a) || (clr_p && match_p))
        count_d = `RST_WORD;
      else
        count_d = count_inc;
    end
    if (!run_rise && match_a)
    begin
      case (pin_action)
        `ACT_LOW:    pin_state_d = 1'b0;
        `ACT_HIGH:   pin_state_d = 1'b1;
        `ACT_TOGGLE: pin_state_d = ~pin_state_q;
        default:     pin_state_d = pin_state_q;
      endcase
    end
  end

  // ***************************************
  // Pin drive
  // ***************************************
  always @*
  begin
    out_d      = 1'b0;
    out_en_n_d = 1'b0;
    case (op_mode)
      `MODE_COMPARE:
        out_d = pin_state_d ^ invert;
      `MODE_PWM:
      begin
        case (pin_action)
          `ACT_NONE: out_d = ~init_level ^ invert;
          `ACT_LOW:  out_d = init_level ^ invert;
          `ACT_HIGH:
            out_d = (pwm_active ? init_level : ~init_level) ^ invert;
          default:   out_d = ~init_level ^ invert;
        endcase
      end
      default:
        out_en_n_d = 1'b1;
    endcase
  end

  // ***************************************
  // Sequential state
  // ***************************************
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      run_ctl_q      <= `RST_BYTE;
      mode_ctl_q     <= `RST_BYTE;
      cmp_a_q        <= `RST_WORD;
      period_cmp_q   <= `RST_BYTE;
      run_prev_q     <= 1'b0;
      count_q        <= `RST_WORD;
      pre_q          <= 6'h00;
      pin_state_q    <= 1'b0;
      flag_a_q       <= 1'b0;
      flag_p_q       <= 1'b0;
      RDATA          <= `RST_BYTE;
      TIMER_OUT      <= 1'b0;
      TIMER_OUT_EN_N <= 1'b1;
      MATCH_A_FLAG   <= 1'b0;
      MATCH_P_FLAG   <= 1'b0;
    end
    else
    begin
      pre_q       <= pre_q + 6'h01;
      run_prev_q  <= run;
      count_q     <= count_d;
      pin_state_q <= pin_state_d;
      if (WR)
      begin
        case (ADDR)
          `OFS_RUN_CONTROL:  run_ctl_q    <= {WDATA[7:3], 3'h0};
          `OFS_MODE_CONTROL: mode_ctl_q   <= WDATA;
          `OFS_CMP_A_LO:     cmp_a_q[7:0] <= WDATA;
          `OFS_CMP_A_HI:     cmp_a_q[15:8] <= WDATA;
          `OFS_PERIOD_CMP:   period_cmp_q <= WDATA;
          default:           cmp_a_q      <= cmp_a_q;
        endcase
      end
      // Writing one clears a flag; a match in the same cycle wins
      // Capture mode raises the P flag only
      flag_a_q <= (match_a & (op_mode != `MODE_CAPTURE))
                  | (flag_a_q & ~(wr_flags & WDATA[`BIT_FLAG_A]));
      // Clear-select counts only in compare and timer modes
      flag_p_q <= (match_p & ~(clr_a && op_mode != `MODE_PWM))
                  | (flag_p_q & ~(wr_flags & WDATA[`BIT_FLAG_P]));
      if (RD)
      begin
        case (ADDR)
          `OFS_RUN_CONTROL:  RDATA <= run_ctl_q;
          `OFS_MODE_CONTROL: RDATA <= mode_ctl_q;
          `OFS_COUNT_LO:     RDATA <= count_q[7:0];
          `OFS_COUNT_HI:     RDATA <= count_q[15:8];
          `OFS_CMP_A_LO:     RDATA <= cmp_a_q[7:0];
          `OFS_CMP_A_HI:     RDATA <= cmp_a_q[15:8];
          `OFS_PERIOD_CMP:   RDATA <= period_cmp_q;
          default:           RDATA <= {6'h00, flag_p_q, flag_a_q};
        endcase
      end
      else
        RDATA <= `RST_BYTE;
      TIMER_OUT      <= out_d;
      TIMER_OUT_EN_N <= out_en_n_d;
      MATCH_A_FLAG   <= flag_a_q;
      MATCH_P_FLAG   <= flag_p_q;
    end
  end

endmodule

/* File: tb/std_timer_compare_pwm_props.sv */
// Port-level checks for the compare/PWM timer
`timescale 1ns/1ps
module std_timer_props
(
  input wire       REF_CLK,
  input wire       RSTN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       TIMER_OUT,
  input wire       TIMER_OUT_EN_N,
  input wire       MATCH_A_FLAG,
  input wire       MATCH_P_FLAG
);
  // ***
  // Register shadow, written like the real registers
  // ***
  logic [7:0] shd_q [0:7];
  wire  [7:0] mode = shd_q[1];
  wire        run  = shd_q[0][3];
  wire  [7:0] exp_rd = shd_q[ADDR] & ((ADDR == 3'h0) ? 8'hf8 : 8'hff);

  always_ff @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
      shd_q <= '{default: 8'h00};
    else if (WR)
      shd_q[ADDR] <= WDATA;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence run_rise;
    $rose(run) && mode[7:6] == 2'h0;
  endsequence
  // Settled for three cycles so a lagging flag copy has caught up
  sequence clr_on_a;
    (mode[7] == mode[6] && mode[0]) [*3];
  endsequence

  chk_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  chk_rd_back: assert property ($past(RD) && $past(ADDR) inside {0, 1, 4, 5, 6}
    |-> RDATA == $past(exp_rd)) else $error("register read back wrong");
  chk_en_off: assert property (mode[6] |=> TIMER_OUT_EN_N)
    else $error("pin driven in a mode without output");
  chk_en_on: assert property (!mode[6] |=> !TIMER_OUT_EN_N)
    else $error("pin not driven in an output mode");
  chk_p_never: assert property (clr_on_a ##0 !MATCH_P_FLAG |=> !MATCH_P_FLAG)
    else $error("P flag raised while clearing on A");
  chk_run_init: assert property (run_rise |=> TIMER_OUT == (mode[3] ^ mode[2]))
    else $error("pin not at initial level after start");
  chk_pin_hold: assert property (mode[7:4] == 4'h0 && $stable(mode) && $stable(run)
    |=> $stable(TIMER_OUT)) else $error("pin moved with no action");
  chk_pin_cause: assert property ($changed(TIMER_OUT) && mode[7:4] == 4'h3
    && mode == $past(mode, 2) && run == $past(run, 2) |-> ##[1:2] MATCH_A_FLAG)
    else $error("pin toggled without an A match");
endmodule

bind std_timer_compare_pwm std_timer_props chk
(
  .REF_CLK        (REF_CLK),
  .RSTN           (RSTN),
  .ADDR           (ADDR),
  .WDATA          (WDATA),
  .WR             (WR),
  .RD             (RD),
  .RDATA          (RDATA),
  .TIMER_OUT      (TIMER_OUT),
  .TIMER_OUT_EN_N (TIMER_OUT_EN_N),
  .MATCH_A_FLAG   (MATCH_A_FLAG),
  .MATCH_P_FLAG   (MATCH_P_FLAG)
);

/* File: tb/test_std_timer_compare_pwm.sv */
// Self-checking bench for the compare/PWM timer
`timescale 1ns/1ps
module test_std_timer_compare_pwm;
  // ***
  // Stimulus and design
  // ***
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ext = 1'b0;
  logic       sub = 1'b0;
  wire  [7:0] rdata;
  wire        pin;
  wire        pin_en_n;
  wire        flag_a;
  wire        flag_p;
  int         err_total = 0;
  int         samples_checked = 0;

  std_timer_compare_pwm uut
  (
    .REF_CLK        (clk),
    .RSTN           (rstn),
    .ADDR           (addr),
    .WDATA          (wdata),
    .WR             (wr),
    .RD             (rd),
    .RDATA          (rdata),
    .EXT_COUNT      (ext),
    .SUB_CLK        (sub),
    .TIMER_OUT      (pin),
    .TIMER_OUT_EN_N (pin_en_n),
    .MATCH_A_FLAG   (flag_a),
    .MATCH_P_FLAG   (flag_p)
  );

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      err_total++;
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask

  // Stop, clear sticky flags, program, then start on select 001
  task automatic start(input logic [7:0] m, input logic [15:0] a, input logic [7:0] p);
    reg_wr(3'h0, 8'h10);
    reg_wr(3'h7, 8'h03);
    reg_wr(3'h1, m);
    reg_wr(3'h4, a[7:0]);
    reg_wr(3'h5, a[15:8]);
    reg_wr(3'h6, p);
    reg_wr(3'h0, 8'h18);
    repeat (2) @(posedge clk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 8; i++) reg_rd(i[2:0], 8'h00);
    reg_wr(3'h0, 8'hf7);
    reg_wr(3'h1, 8'h5a);
    reg_wr(3'h4, 8'ha5);
    reg_wr(3'h5, 8'h3c);
    reg_wr(3'h6, 8'hc3);
    reg_wr(3'h2, 8'hff);
    reg_rd(3'h0, 8'hf0);
    reg_rd(3'h1, 8'h5a);
    reg_rd(3'h4, 8'ha5);
    reg_rd(3'h5, 8'h3c);
    reg_rd(3'h6, 8'hc3);
    reg_rd(3'h2, 8'h00);
  endtask

  task automatic t_cmp(input logic [1:0] act, input logic ini, input logic inv);
    logic hit;
    logic prev;
    int   n;
    hit = (act == 2'h0) ? ini : (act == 2'h3) ? ~ini : act[1];
    start({2'h0, act, ini, inv, 2'h1}, 16'h0003, 8'h00);
    #1 check(pin, ini ^ inv);
    repeat (3) @(posedge clk);
    #1 check(pin, hit ^ inv);
    check(pin_en_n, 1'b0);
    check({flag_a, flag_p}, 2'h2);
    n = 0;
    prev = pin;
    repeat (30)
    begin
      @(posedge clk);
      #1 n += (pin != prev);
      prev = pin;
    end
    check(n, (act == 2'h3) ? 10 : 0);
    reg_wr(3'h0, 8'h10);
    reg_wr(3'h0, 8'h18);
    repeat (2) @(posedge clk);
    #1 check(pin, ini ^ inv);
  endtask

  // Clear on P at 256 keeps the count high byte at zero
  task automatic t_cnt(input logic [7:0] m);
    start(m, 16'h0010, 8'h01);
    repeat (300) @(posedge clk);
    #1 check({flag_a, flag_p}, 2'h3);
    check(pin_en_n, m[6]);
    reg_rd(3'h3, 8'h00);
  endtask

  task automatic t_pwm(input logic [7:0] m, input logic [15:0] a, input int e);
    int n;
    start(m, a, 8'h01);
    repeat (8) @(posedge clk);
    n = 0;
    repeat (256)
    begin
      @(posedge clk);
      #1 n += pin;
    end
    check(n, e);
    if (a < 16'h0100)
      check(flag_a, 1'b1);
    if (!m[1])
      check(flag_p, 1'b1);
  endtask

  // Clear on A=16 in compare mode; cycles to the A flag per tick source
  task automatic t_sel(input logic [2:0] s, input int lo, input int hi);
    int c;
    reg_wr(3'h0, 8'h10);
    reg_wr(3'h7, 8'h03);
    reg_wr(3'h1, 8'h01);
    reg_wr(3'h4, 8'h10);
    reg_wr(3'h5, 8'h00);
    reg_wr(3'h6, 8'h00);
    reg_wr(3'h0, {1'b0, s, 4'h8});
    c = 0;
    while (c < 400)
    begin
      @(posedge clk);
      if (c[1:0] == 2'h0)
      begin
        ext <= ~ext;
        sub <= ~sub;
      end
      c++;
      #1;
      if (flag_a)
        break;
    end
    check(c >= lo && c <= hi, 1'b1);
  endtask

  task automatic wrap_up;
    $display("Checked %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_cmp(2'h0, 1'b1, 1'b0);
    t_cmp(2'h1, 1'b1, 1'b0);
    t_cmp(2'h2, 1'b0, 1'b1);
    t_cmp(2'h3, 1'b0, 1'b0);
    t_cnt(8'h00);
    t_cnt(8'hc0);
    t_pwm(8'ha8, 16'h0040, 64);
    t_pwm(8'hac, 16'h0040, 192);
    t_pwm(8'ha0, 16'h0040, 192);
    t_pwm(8'ha8, 16'h0200, 256);
    t_pwm(8'haa, 16'h0080, 256);
    t_pwm(8'h88, 16'h0040, 0);
    t_pwm(8'h98, 16'h0040, 256);
    t_sel(3'h1, 18, 18);
    t_sel(3'h0, 62, 68);
    t_sel(3'h2, 240, 262);
    t_sel(3'h4, 110, 145);
    t_sel(3'h6, 110, 145);
    t_sel(3'h7, 110, 145);
    wrap_up();
  end

  // Tests need about 4000 cycles; allow five times that
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
